/* rtl/pwm_timer.sv */
// dual-slope symmetric pwm timer with apb registers
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module pwm_timer
  import pwm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [1:0]  pwm_out,
  output logic      [1:0]  pwm_oe_n
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [4:0]  ctrl_b;
    logic [15:0] cnt;
    logic        down;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] capt;
    logic [3:0]  flags;
    logic [3:0]  pin_cfg;
    logic [1:0]  oc;
    logic [1:0]  pin_out;
    logic [1:0]  oe_n;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tmr_state_t;

  tmr_state_t st_ff;
  tmr_state_t nxt_st;

  tick_if tk ();

  tick_prescaler u_prescaler (
    .clk   (clk),
    .rst_n (rst_n),
    .tk    (tk)
  );

  // ------------------------------------------------------------------
  // decode of the current mode
  // ------------------------------------------------------------------
  logic [3:0]  wave;
  logic        pfc;
  logic [15:0] top_raw;
  logic [15:0] top;
  logic        tick;
  logic        up;
  logic [1:0]  om [2];
  logic [1:0]  hit;

  always_comb begin
    wave = {st_ff.ctrl_b[CB_WAVE_HI_LSB +: 2], st_ff.ctrl_a[1:0]};
    pfc = (wave == WAVE_PFC_CAPT) || (wave == WAVE_PFC_CMPA);
    top_raw = (wave == WAVE_PFC_CMPA) ? st_ff.cmp_a : st_ff.capt;
    // a top below three would stall the slopes; clamp to the minimum
    top = (top_raw < TOP_MIN) ? TOP_MIN : top_raw;
    tick = tk.tick && pfc;
    // top belongs to the falling slope and bottom to the rising one, so
    // compare at top keeps a non-inverted output high, at zero low
    up = (st_ff.cnt == 16'h0000)
         || (!st_ff.down && (st_ff.cnt < top));
    om[0] = st_ff.ctrl_a[CA_MODE_A_LSB +: 2];
    om[1] = st_ff.ctrl_a[CA_MODE_B_LSB +: 2];
    hit[0] = (st_ff.cnt == st_ff.cmp_a);
    hit[1] = (st_ff.cnt == st_ff.cmp_b);
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic        acc;
  logic        wr;
  logic [31:0] rd;
  logic        bad;
  logic [3:0]  set_fl;
  logic [3:0]  clr_fl;
  logic [3:0]  new_wave;
  logic [1:0]  new_om [2];
  logic [1:0]  link;

  always_comb begin
    nxt_st = st_ff;
    set_fl = 4'h0;
    clr_fl = 4'h0;
    acc = psel && penable && st_ff.pready;
    wr  = acc && pwrite;
    bad = 1'b0;
    rd  = 32'h0000_0000;
    unique case (paddr)
      OFF_CTRL_A: rd = {24'h00_0000, st_ff.ctrl_a};
      OFF_CTRL_B: rd = {27'h000_0000, st_ff.ctrl_b};
      OFF_COUNT:  rd = {16'h0000, st_ff.cnt};
      OFF_CMP_A:  rd = {16'h0000, st_ff.buf_a};
      OFF_CMP_B:  rd = {16'h0000, st_ff.buf_b};
      OFF_CAPT:   rd = {16'h0000, st_ff.capt};
      OFF_FLAGS:  rd = {28'h000_0000, st_ff.flags};
      OFF_PIN:    rd = {28'h000_0000, st_ff.pin_cfg};
      default:    bad = 1'b1;
    endcase

    // one wait state: answer prepared in the first access cycle
    nxt_st.pready = psel && penable && !st_ff.pready;
    if (psel && penable && !st_ff.pready) begin
      nxt_st.prdata  = rd;
      nxt_st.pslverr = bad;
    end else if (acc) begin
      nxt_st.pslverr = 1'b0;
    end

    // counter, only in the two dual-slope modes
    if (tick) begin
      if (st_ff.cnt == 16'h0000) begin
        nxt_st.cmp_a = st_ff.buf_a;
        nxt_st.cmp_b = st_ff.buf_b;
        set_fl[FL_OVF] = 1'b1;
        nxt_st.cnt  = 16'h0001;
        nxt_st.down = 1'b0;
      end else if (!st_ff.down && st_ff.cnt >= top) begin
        nxt_st.down = 1'b1;
        nxt_st.cnt  = st_ff.cnt - 16'h0001;
        if (wave == WAVE_PFC_CAPT) begin
          set_fl[FL_CAPT] = 1'b1;
        end else begin
          set_fl[FL_CMPA] = 1'b1;
        end
      end else if (st_ff.down) begin
        nxt_st.cnt = st_ff.cnt - 16'h0001;
      end else begin
        nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
      set_fl[FL_CMPA] = set_fl[FL_CMPA] | hit[0];
      set_fl[FL_CMPB] = set_fl[FL_CMPB] | hit[1];
      for (int i = 0; i < 2; i++) begin
        if (hit[i]) begin
          unique case (om[i])
            OM_NONINV: nxt_st.oc[i] = !up;
            OM_INV:    nxt_st.oc[i] = up;
            OM_TOGGLE: begin
              if (i == 0 && wave[3]) begin
                nxt_st.oc[i] = !st_ff.oc[i];
              end
            end
            OM_OFF:    nxt_st.oc[i] = st_ff.oc[i];
          endcase
        end
      end
    end else if (!pfc) begin
      // outside the dual-slope modes compares follow writes at once
      nxt_st.cmp_a = st_ff.buf_a;
      nxt_st.cmp_b = st_ff.buf_b;
    end

    // software writes; a count write overrides the tick update
    if (wr) begin
      unique case (paddr)
        OFF_CTRL_A: nxt_st.ctrl_a = pwdata[7:0] & CA_WMASK;
        OFF_CTRL_B: nxt_st.ctrl_b = pwdata[4:0];
        OFF_COUNT:  nxt_st.cnt    = pwdata[15:0];
        OFF_CMP_A:  nxt_st.buf_a  = pwdata[15:0];
        OFF_CMP_B:  nxt_st.buf_b  = pwdata[15:0];
        OFF_CAPT:   nxt_st.capt   = pwdata[15:0];
        OFF_FLAGS:  clr_fl        = pwdata[3:0];
        OFF_PIN:    nxt_st.pin_cfg = pwdata[3:0];
        default:    nxt_st.pin_cfg = st_ff.pin_cfg;
      endcase
    end
    // a flag event in the clearing cycle is kept
    nxt_st.flags = (st_ff.flags & ~clr_fl) | set_fl;

    // pin drive: output mode connects, direction and enable gate; the
    // toggle code reaches channel a only, and only with the top mode bit
    new_wave = {nxt_st.ctrl_b[CB_WAVE_HI_LSB +: 2], nxt_st.ctrl_a[1:0]};
    for (int i = 0; i < 2; i++) begin
      new_om[i] = nxt_st.ctrl_a[CA_MODE_B_LSB + 2 - 2 * i +: 2];
      link[i] = (new_om[i] != OM_OFF)
                && !(new_om[i] == OM_TOGGLE
                     && (i == 1 || !new_wave[3]));
      nxt_st.pin_out[i] = nxt_st.oc[i];
      nxt_st.oe_n[i] = !(link[i] && nxt_st.pin_cfg[PIN_DIR_LSB + i]
                         && nxt_st.pin_cfg[PIN_EN_LSB + i]);
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff        <= '0;
      st_ff.ctrl_a <= CTRL_A_RST;
      st_ff.ctrl_b <= CTRL_B_RST;
      st_ff.oe_n   <= 2'h3;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tk.sel   = st_ff.ctrl_b[2:0];
  assign prdata   = st_ff.prdata;
  assign pready   = st_ff.pready;
  assign pslverr  = st_ff.pslverr;
  assign pwm_out  = st_ff.pin_out;
  assign pwm_oe_n = st_ff.oe_n;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  logic cnt_wr;
  assign cnt_wr = wr && (paddr == OFF_COUNT);

  a_count_rising: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !cnt_wr && !st_ff.down && st_ff.cnt != 16'h0000
     && st_ff.cnt < top) |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
    else $error("counter did not step up");

  a_count_falling: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !cnt_wr && st_ff.down && st_ff.cnt != 16'h0000) |=>
      st_ff.cnt == $past(st_ff.cnt) - 16'h0001)
    else $error("counter did not step down");

  a_bottom_turn: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !cnt_wr && st_ff.cnt == 16'h0000) |=>
      st_ff.cnt == 16'h0001 && !st_ff.down)
    else $error("counter did not turn up at bottom");

  a_count_held: assert property (@(posedge clk) disable iff (!rst_n)
    (!pfc && !cnt_wr) |=> st_ff.cnt == $past(st_ff.cnt))
    else $error("counter moved outside the dual-slope modes");

  a_turn_at_top: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !cnt_wr && !st_ff.down && st_ff.cnt == top) |=>
      st_ff.down && st_ff.cnt == $past(st_ff.cnt) - 16'h0001)
    else $error("counter did not turn at top");

  a_bottom_load: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && st_ff.cnt == 16'h0000) |=>
      st_ff.flags[FL_OVF] && st_ff.cmp_a == $past(st_ff.buf_a))
    else $error("no overflow flag or load at bottom");

  a_ovf_no_stray: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_ff.flags[FL_OVF] && !(tick && st_ff.cnt == 16'h0000)) |=>
      !st_ff.flags[FL_OVF])
    else $error("overflow flag set away from bottom");

  a_hold_compare: assert property (@(posedge clk) disable iff (!rst_n)
    (pfc && st_ff.cnt != 16'h0000) |=>
      st_ff.cmp_b == $past(st_ff.cmp_b))
    else $error("compare b changed away from bottom");

  a_match_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && st_ff.cnt == st_ff.cmp_a) |=> st_ff.flags[FL_CMPA])
    else $error("compare a match flag not set");

  a_match_flag_b: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && st_ff.cnt == st_ff.cmp_b) |=> st_ff.flags[FL_CMPB])
    else $error("compare b match flag not set");

  a_noninv_up: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && up && hit[0] && om[0] == OM_NONINV) |=> !st_ff.oc[0])
    else $error("non-inverted output not cleared on up match");

  a_noninv_down: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !up && hit[0] && om[0] == OM_NONINV) |=> st_ff.oc[0])
    else $error("non-inverted output not set on down match");

  a_inv_up: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && up && hit[1] && om[1] == OM_INV) |=> st_ff.oc[1])
    else $error("inverted output not set on up match");

  a_inv_down: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !up && hit[1] && om[1] == OM_INV) |=> !st_ff.oc[1])
    else $error("inverted output not cleared on down match");

  a_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && hit[0] && om[0] == OM_TOGGLE && wave[3]) |=>
      st_ff.oc[0] != $past(st_ff.oc[0]))
    else $error("channel a did not toggle on match");

  a_capt_top: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && wave == WAVE_PFC_CAPT && !st_ff.down && st_ff.cnt == top)
      |=> st_ff.flags[FL_CAPT])
    else $error("capture flag not set at top");

  a_capt_no_stray: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_ff.flags[FL_CAPT] && !(tick && wave == WAVE_PFC_CAPT
      && !st_ff.down && st_ff.cnt >= top)) |=> !st_ff.flags[FL_CAPT])
    else $error("capture flag set away from top");

  a_cmpa_top: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && wave == WAVE_PFC_CMPA && !st_ff.down && st_ff.cnt == top)
      |=> st_ff.flags[FL_CMPA])
    else $error("compare a flag not set at top");

  a_pin_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !pwm_oe_n[0] |-> st_ff.pin_cfg[PIN_DIR_LSB]
      && st_ff.pin_cfg[PIN_EN_LSB])
    else $error("pin driven without direction and enable");

  a_pin_gate_b: assert property (@(posedge clk) disable iff (!rst_n)
    !pwm_oe_n[1] |-> st_ff.pin_cfg[PIN_DIR_LSB + 1]
      && st_ff.pin_cfg[PIN_EN_LSB + 1])
    else $error("pin b driven without direction and enable");

  a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.ctrl_a[3:2] == 2'h0)
    else $error("reserved control bits not zero");

  a_apb_answer: assert property (@(posedge clk) disable iff (!rst_n)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not one cycle after access");
endmodule

/* inc/pwm_pkg.sv */
// shared constants of the dual-slope pwm timer
package pwm_pkg;
  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_COUNT  = 8'h08;
  localparam logic [7:0] OFF_CMP_A  = 8'h0c;
  localparam logic [7:0] OFF_CMP_B  = 8'h10;
  localparam logic [7:0] OFF_CAPT   = 8'h14;
  localparam logic [7:0] OFF_FLAGS  = 8'h18;
  localparam logic [7:0] OFF_PIN    = 8'h1c;
  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int CA_MODE_A_LSB = 6;
  localparam int CA_MODE_B_LSB = 4;
  localparam logic [7:0] CA_WMASK = 8'hf3;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam int CB_WAVE_HI_LSB = 3;
  localparam logic [4:0] CTRL_B_RST = 5'h00;
  localparam int FL_OVF  = 0;
  localparam int FL_CMPA = 1;
  localparam int FL_CMPB = 2;
  localparam int FL_CAPT = 3;
  // pin register: bits 1:0 direction, bits 3:2 output enable
  localparam int PIN_DIR_LSB = 0;
  localparam int PIN_EN_LSB  = 2;
  // ------------------------------------------------------------------
  // modes and encodings
  // ------------------------------------------------------------------
  localparam logic [3:0] WAVE_PFC_CAPT = 4'h8;
  localparam logic [3:0] WAVE_PFC_CMPA = 4'h9;
  localparam logic [1:0] OM_OFF    = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_NONINV = 2'h2;
  localparam logic [1:0] OM_INV    = 2'h3;
  localparam logic [15:0] TOP_MIN  = 16'h0003;
  // prescaler select codes and divide counts minus one
  localparam logic [2:0] PS_STOP = 3'h0;
  localparam logic [2:0] PS_1    = 3'h1;
  localparam logic [2:0] PS_8    = 3'h2;
  localparam logic [2:0] PS_64   = 3'h3;
  localparam logic [2:0] PS_256  = 3'h4;
  localparam logic [2:0] PS_1024 = 3'h5;
  localparam logic [9:0] DIV_1    = 10'h000;
  localparam logic [9:0] DIV_8    = 10'h007;
  localparam logic [9:0] DIV_64   = 10'h03f;
  localparam logic [9:0] DIV_256  = 10'h0ff;
  localparam logic [9:0] DIV_1024 = 10'h3ff;
endpackage

/* inc/tick_if.sv */
// timer tick link between the timer core and its prescaler
`timescale 1ns/1ps
interface tick_if;
  logic [2:0] sel;
  logic       tick;
  modport core (output sel, input tick);
  modport div  (input sel, output tick);
endinterface

/* rtl/tick_prescaler.sv */
// prescaler making the one-cycle timer tick enable
`timescale 1ns/1ps
module tick_prescaler
  import pwm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  tick_if.div       tk
);
  typedef struct packed {
    logic [9:0] cnt;
    logic       tick;
  } ps_state_t;

  ps_state_t  ps_ff;
  ps_state_t  nxt_ps;
  logic [9:0] lim;
  logic       run;

  always_comb begin
    run = 1'b1;
    lim = DIV_1;
    unique case (tk.sel)
      PS_1:    lim = DIV_1;
      PS_8:    lim = DIV_8;
      PS_64:   lim = DIV_64;
      PS_256:  lim = DIV_256;
      PS_1024: lim = DIV_1024;
      default: run = 1'b0;
    endcase
    nxt_ps = ps_ff;
    nxt_ps.tick = 1'b0;
    if (!run) begin
      nxt_ps.cnt = 10'h000;
    end else if (ps_ff.cnt >= lim) begin
      nxt_ps.cnt  = 10'h000;
      nxt_ps.tick = 1'b1;
    end else begin
      nxt_ps.cnt = ps_ff.cnt + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ps_ff <= '0;
    end else begin
      ps_ff <= nxt_ps;
    end
  end

  assign tk.tick = ps_ff.tick;

  a_tick_gap_64: assert property (@(posedge clk) disable iff (!rst_n)
    (tk.sel == PS_64 && $stable(tk.sel) && ps_ff.tick) |=>
      !ps_ff.tick [*8])
    else $error("tick repeated too soon at divide by 64");
endmodule

/* test/pwm_load.sv */
// load model: pin levels seen by the load behind the pwm outputs
`timescale 1ns/1ps
module pwm_load (
  input  wire logic [1:0] pwm_out,
  input  wire logic [1:0] pwm_oe_n,
  output logic      [1:0] pin
);
  // an undriven pin sinks to the load's pull-down, never keeps its last level
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin[i] = (pwm_oe_n[i] === 1'b0) ? pwm_out[i] : 1'b0;
    end
  end
endmodule

/* test/pwm_timer_tb.sv */
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/1ps
module pwm_timer_tb;
  import pwm_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pwm_out;
  logic [1:0]  pwm_oe_n;
  logic [1:0]  pin;
  logic [31:0] rdv;
  logic        er;
  int          n_mismatch;
  int          n_tests;
  int          hi_a;
  int          hi_b;
  int          rise_b;
  int          div_n[5] = '{1, 8, 64, 256, 1024};

  pwm_timer u_pwm_timer (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n));
  pwm_load u_pwm_load (.pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .pin(pin));

  always #12.5 clk = ~clk;

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    er  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // counts over whole periods, so the result does not depend on phase
  task meas(input int cyc);
    logic [1:0] prev;
    hi_a   = 0;
    hi_b   = 0;
    rise_b = 0;
    @(posedge clk);
    prev = pin;
    repeat (cyc) begin
      @(posedge clk);
      if (pin[0] === 1'b1) hi_a++;
      if (pin[1] === 1'b1) hi_b++;
      if (pin[1] === 1'b1 && prev[1] === 1'b0) rise_b++;
      prev = pin;
    end
  endtask

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk({30'h0, pwm_oe_n}, 32'h3);
    apb(OFF_CTRL_A, 1'b0, 32'h0);
    chk(rdv, 32'h0);
    apb(OFF_CTRL_A, 1'b1, 32'hff);
    apb(OFF_CTRL_A, 1'b0, 32'h0);
    chk(rdv, 32'hf3);
    apb(8'h20, 1'b0, 32'h0);
    chk({31'h0, er}, 32'h1);
    // mode 8: top 8 from capture, a inverted at 3, b plain at top
    apb(OFF_CAPT, 1'b1, 32'h8);
    apb(OFF_CMP_A, 1'b1, 32'h3);
    apb(OFF_CMP_B, 1'b1, 32'h8);
    apb(OFF_CTRL_A, 1'b1, 32'he0);
    apb(OFF_PIN, 1'b1, 32'hf);
    apb(OFF_CTRL_B, 1'b1, 32'h11);
    repeat (40) @(posedge clk);
    meas(32);
    chk(32'(hi_a), 32'd20);
    chk(32'(hi_b), 32'd32);
    apb(OFF_FLAGS, 1'b0, 32'h0);
    chk(rdv, 32'hf);
    // mode 9: top 4 from compare a, a toggles, b at zero stays low
    apb(OFF_CMP_A, 1'b1, 32'h4);
    apb(OFF_CMP_B, 1'b1, 32'h0);
    apb(OFF_CTRL_A, 1'b1, 32'h61);
    repeat (40) @(posedge clk);
    apb(OFF_FLAGS, 1'b1, 32'hf);
    repeat (20) @(posedge clk);
    apb(OFF_FLAGS, 1'b0, 32'h0);
    chk(rdv, 32'h7);
    meas(32);
    chk(32'(hi_a), 32'd16);
    chk(32'(hi_b), 32'd0);
    // every prescaler: b plain at 2 gives half duty, 2 pulses per window
    apb(OFF_CMP_B, 1'b1, 32'h2);
    for (int i = 0; i < 5; i++) begin
      apb(OFF_CTRL_B, 1'b1, 32'h10 | 32'(i + 1));
      repeat (16 * div_n[i] + 10) @(posedge clk);
      meas(16 * div_n[i]);
      chk(32'(hi_b), 32'(8 * div_n[i]));
      chk(32'(rise_b), 32'd2);
    end
    // mode 8 again: a plain and b inverted, both at 3 below top 8
    apb(OFF_CTRL_B, 1'b1, 32'h11);
    apb(OFF_CMP_A, 1'b1, 32'h3);
    apb(OFF_CMP_B, 1'b1, 32'h3);
    apb(OFF_CTRL_A, 1'b1, 32'hb0);
    repeat (40) @(posedge clk);
    meas(32);
    chk(32'(hi_a), 32'd12);
    chk(32'(hi_b), 32'd20);
    // direction or enable alone keeps the pin released
    for (int i = 0; i < 2; i++) begin
      apb(OFF_PIN, 1'b1, (i == 0) ? 32'h3 : 32'hc);
      repeat (4) @(posedge clk);
      chk({30'h0, pwm_oe_n}, 32'h3);
      chk({30'h0, pin}, 32'h0);
    end
    end_sim;
  end

  initial begin
    #(80000 * 25);
    n_mismatch++;
    end_sim;
  end
endmodule
